/* core/ndc_host.sv */
// Overview of operation
// - Eight I/O lines carry command, address, data
// - Command latched on write rising edge, CLE high
// - Address latched on write rising edge, ALE high
// - Both read strobe edges present new data
// - Ready/busy open drain, board pulls up
// - Strobe edge-aligned on read, centred on write
// - Two channels, four of the eight chip enables on each
// - Between plane phases only status, reset, program or copy
`timescale 1ns/1ps
`include "ndc_map.svh"
module ndc_host
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_link,
  input wire logic req_valid,
  output logic req_ready,
  input wire ndc_pkg::ndc_req_s req,
  output logic rsp_valid,
  output ndc_pkg::ndc_rsp_s rsp,
  input wire logic protect,
  output logic [`NDC_CE_NUM-1:0] chip_ready,
  output ndc_pkg::ndc_pin_s [`NDC_CH_NUM-1:0] pins,
  output logic [`NDC_CE_NUM-1:0] ce_n,
  output logic [`NDC_CH_NUM-1:0] wp_n,
  input wire logic [`NDC_CH_NUM-1:0][7:0] io_in,
  input wire logic [`NDC_CH_NUM-1:0] dqs_in,
  input wire logic [`NDC_RB_NUM-1:0] rb_n
);

  function automatic logic chan_of(input logic [2:0] chip);
    chan_of = chip[2];
  endfunction

  function automatic logic [1:0] rb_of(input logic [2:0] chip);
    rb_of = chip[2:1];
  endfunction

  function automatic logic cmd_allowed_mid_plane(input logic [7:0] c);
    cmd_allowed_mid_plane = (c == `NDC_CMD_STATUS) || (c == `NDC_CMD_CHIP1_STATUS) ||
      (c == `NDC_CMD_RESET) || (c == `NDC_CMD_PROG1) || (c == `NDC_CMD_PROG2) ||
      (c == `NDC_CMD_COPY);
  endfunction

  // System domain
  ndc_pkg::ndc_sys_state_e state;
  ndc_pkg::ndc_sys_state_e next_state;
  ndc_pkg::ndc_req_s cur;
  ndc_pkg::ndc_req_s next_cur;
  logic req_tgl;
  logic next_req_tgl;
  logic next_rsp_valid;
  ndc_pkg::ndc_rsp_s next_rsp;
  logic [`NDC_CH_NUM-1:0] next_wp_n;
  logic [`NDC_RB_NUM-1:0] rb_sync;
  logic ack_pulse;
  logic [`NDC_RB_NUM-1:0] rb_ready;

  // Link domain
  ndc_pkg::ndc_link_state_e lstate;
  ndc_pkg::ndc_link_state_e next_lstate;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  ndc_pkg::ndc_pin_s lpin;
  ndc_pkg::ndc_pin_s next_lpin;
  logic [`NDC_CE_NUM-1:0] next_ce_n;
  ndc_pkg::ndc_rsp_s lrsp;
  ndc_pkg::ndc_rsp_s next_lrsp;
  logic ack_tgl;
  logic next_ack_tgl;
  logic two_plane;
  logic next_two_plane;
  logic lchan;
  logic next_lchan;
  logic go_pulse;
  logic [`NDC_CH_NUM-1:0][7:0] io_sync;
  logic [`NDC_CH_NUM-1:0] dqs_sync;

  // Ready/busy is an open-drain line; the pull-up sits on the board side
  ndc_sync #(.W(`NDC_RB_NUM)) u_rb_sync
  (
    .clk(clk_sys),
    .arst_n(arst_n),
    .din(rb_n),
    .dout(rb_sync)
  );

  assign rb_ready = rb_sync;

  generate
    for (genvar g = 0; g < `NDC_CE_NUM; g++)
    begin : g_ready
      assign chip_ready[g] = rb_ready[rb_of(3'(g))];
    end
  endgenerate

  ndc_pulse_cross u_ack_cross
  (
    .clk(clk_sys),
    .arst_n(arst_n),
    .toggle_in(ack_tgl),
    .pulse(ack_pulse)
  );

  assign req_ready = (state == ndc_pkg::NDC_S_IDLE);

  always_comb
  begin
    next_state = state;
    next_cur = cur;
    next_req_tgl = req_tgl;
    next_rsp_valid = 1'b0;
    next_rsp = rsp;
    next_wp_n = {`NDC_CH_NUM{~protect}};
    unique case (state)
      ndc_pkg::NDC_S_IDLE:
      begin
        if (req_valid)
        begin
          next_cur = req;
          if (req.op == ndc_pkg::NDC_OP_WAIT)
            next_state = ndc_pkg::NDC_S_WAIT;
          else
          begin
            next_req_tgl = ~req_tgl;
            next_state = ndc_pkg::NDC_S_LINK;
          end
        end
      end
      ndc_pkg::NDC_S_LINK:
      begin
        if (ack_pulse)
        begin
          next_rsp = lrsp;
          next_rsp_valid = 1'b1;
          next_state = ndc_pkg::NDC_S_IDLE;
        end
      end
      ndc_pkg::NDC_S_WAIT:
      begin
        if (chip_ready[cur.chip])
        begin
          next_rsp = '{err: 1'b0, data: 16'h0000};
          next_rsp_valid = 1'b1;
          next_state = ndc_pkg::NDC_S_IDLE;
        end
      end
      default:
        next_state = ndc_pkg::NDC_S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ndc_pkg::NDC_S_IDLE;
      cur <= '0;
      req_tgl <= 1'b0;
      rsp_valid <= 1'b0;
      rsp <= '0;
      wp_n <= `NDC_WP_N_RST;
    end
    else
    begin
      state <= next_state;
      cur <= next_cur;
      req_tgl <= next_req_tgl;
      rsp_valid <= next_rsp_valid;
      rsp <= next_rsp;
      wp_n <= next_wp_n;
    end
  end

  // Link side; cur stays stable from the toggle until the ack returns
  ndc_pulse_cross u_req_cross
  (
    .clk(clk_link),
    .arst_n(arst_n),
    .toggle_in(req_tgl),
    .pulse(go_pulse)
  );

  ndc_sync #(.W(`NDC_CH_NUM * 9)) u_io_sync
  (
    .clk(clk_link),
    .arst_n(arst_n),
    .din({io_in, dqs_in}),
    .dout({io_sync, dqs_sync})
  );

  always_comb
  begin
    next_lstate = lstate;
    next_cnt = cnt;
    next_lpin = lpin;
    next_ce_n = ce_n;
    next_lrsp = lrsp;
    next_ack_tgl = ack_tgl;
    next_two_plane = two_plane;
    next_lchan = lchan;
    unique case (lstate)
      ndc_pkg::NDC_L_IDLE:
      begin
        next_lpin = ndc_pkg::NDC_PIN_IDLE;
        if (go_pulse)
        begin
          next_lchan = chan_of(cur.chip);
          next_ce_n = ~(`NDC_CE_NUM'(1) << cur.chip);
          next_lrsp = '0;
          next_cnt = 4'h0;
          unique case (cur.op)
            ndc_pkg::NDC_OP_CMD:
            begin
              if (two_plane && !cmd_allowed_mid_plane(cur.data[7:0]))
              begin
                next_lrsp.err = 1'b1;
                next_ack_tgl = ~ack_tgl;
              end
              else
              begin
                if (cur.data[7:0] == `NDC_CMD_PLANE1)
                  next_two_plane = 1'b1;
                else if ((cur.data[7:0] == `NDC_CMD_PROG1) ||
                  (cur.data[7:0] == `NDC_CMD_PROG2) || (cur.data[7:0] == `NDC_CMD_COPY))
                  next_two_plane = 1'b0;
                next_lpin.cle = 1'b1;
                next_lpin.we_n = 1'b0;
                next_lpin.io_out = cur.data[7:0];
                next_lpin.io_oe_n = 1'b0;
                next_lstate = ndc_pkg::NDC_L_CA_SET;
              end
            end
            ndc_pkg::NDC_OP_ADDR:
            begin
              next_lpin.ale = 1'b1;
              next_lpin.we_n = 1'b0;
              next_lpin.io_out = cur.data[7:0];
              next_lpin.io_oe_n = 1'b0;
              next_lstate = ndc_pkg::NDC_L_CA_SET;
            end
            ndc_pkg::NDC_OP_WRITE:
            begin
              next_lpin.io_out = cur.data[7:0];
              next_lpin.io_oe_n = 1'b0;
              next_lpin.dqs_out = 1'b0;
              next_lpin.dqs_oe_n = 1'b0;
              next_lstate = ndc_pkg::NDC_L_W0;
            end
            ndc_pkg::NDC_OP_READ:
            begin
              next_lpin.read_strobe_n = 1'b0;
              next_lstate = ndc_pkg::NDC_L_R_LO;
            end
            default:
            begin
              next_lrsp.err = 1'b1;
              next_ack_tgl = ~ack_tgl;
            end
          endcase
        end
      end
      ndc_pkg::NDC_L_CA_SET:
      begin
        next_lpin.we_n = 1'b1;
        next_lstate = ndc_pkg::NDC_L_CA_LATCH;
      end
      ndc_pkg::NDC_L_CA_LATCH:
      begin
        next_lpin = ndc_pkg::NDC_PIN_IDLE;
        next_ack_tgl = ~ack_tgl;
        next_lstate = ndc_pkg::NDC_L_IDLE;
      end
      ndc_pkg::NDC_L_W0:
      begin
        next_lpin.dqs_out = 1'b1;
        next_lstate = ndc_pkg::NDC_L_W1;
      end
      ndc_pkg::NDC_L_W1:
      begin
        next_lpin.io_out = cur.data[15:8];
        next_lstate = ndc_pkg::NDC_L_W2;
      end
      ndc_pkg::NDC_L_W2:
      begin
        next_lpin.dqs_out = 1'b0;
        next_lstate = ndc_pkg::NDC_L_W3;
      end
      ndc_pkg::NDC_L_W3:
      begin
        next_lpin = ndc_pkg::NDC_PIN_IDLE;
        next_ack_tgl = ~ack_tgl;
        next_lstate = ndc_pkg::NDC_L_IDLE;
      end
      ndc_pkg::NDC_L_R_LO:
      begin
        next_cnt = cnt + 4'h1;
        if ((cnt >= 4'(`NDC_RD_WAIT_CYC)) && dqs_sync[lchan])
        begin
          next_lrsp.data[7:0] = io_sync[lchan];
          next_lpin.read_strobe_n = 1'b1;
          next_cnt = 4'h0;
          next_lstate = ndc_pkg::NDC_L_R_HI;
        end
        else if (cnt == 4'(`NDC_RD_TIMEOUT_CYC))
        begin
          next_lrsp.err = 1'b1;
          next_lpin = ndc_pkg::NDC_PIN_IDLE;
          next_ack_tgl = ~ack_tgl;
          next_lstate = ndc_pkg::NDC_L_IDLE;
        end
      end
      ndc_pkg::NDC_L_R_HI:
      begin
        next_cnt = cnt + 4'h1;
        if ((cnt >= 4'(`NDC_RD_WAIT_CYC)) && !dqs_sync[lchan])
        begin
          next_lrsp.data[15:8] = io_sync[lchan];
          next_ack_tgl = ~ack_tgl;
          next_lstate = ndc_pkg::NDC_L_IDLE;
        end
        else if (cnt == 4'(`NDC_RD_TIMEOUT_CYC))
        begin
          next_lrsp.err = 1'b1;
          next_ack_tgl = ~ack_tgl;
          next_lstate = ndc_pkg::NDC_L_IDLE;
        end
      end
      default:
      begin
        next_lpin = ndc_pkg::NDC_PIN_IDLE;
        next_lstate = ndc_pkg::NDC_L_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_link or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lstate <= ndc_pkg::NDC_L_IDLE;
      cnt <= 4'h0;
      lpin <= ndc_pkg::NDC_PIN_IDLE;
      ce_n <= `NDC_CE_N_RST;
      lrsp <= '0;
      ack_tgl <= 1'b0;
      two_plane <= 1'b0;
      lchan <= 1'b0;
    end
    else
    begin
      lstate <= next_lstate;
      cnt <= next_cnt;
      lpin <= next_lpin;
      ce_n <= next_ce_n;
      lrsp <= next_lrsp;
      ack_tgl <= next_ack_tgl;
      two_plane <= next_two_plane;
      lchan <= next_lchan;
    end
  end

  // Only the addressed channel sees the active pin set
  generate
    for (genvar c = 0; c < `NDC_CH_NUM; c++)
    begin : g_chan
      assign pins[c] = (lchan == 1'(c)) ? lpin : ndc_pkg::NDC_PIN_IDLE;
    end
  endgenerate

endmodule

/* core/ndc_map.svh */
`ifndef NDC_MAP_SVH
`define NDC_MAP_SVH

// Pin counts
`define NDC_CH_NUM 2
`define NDC_CE_NUM 8
`define NDC_RB_NUM 4

// Command bytes that matter for the two-plane sequence check
`define NDC_CMD_PLANE1 8'h11
`define NDC_CMD_STATUS 8'h70
`define NDC_CMD_CHIP1_STATUS 8'hf1
`define NDC_CMD_RESET 8'hff
`define NDC_CMD_PROG1 8'h80
`define NDC_CMD_PROG2 8'h81
`define NDC_CMD_COPY 8'h85

// Link timing
`define NDC_LINK_PERIOD_NS 32
`define NDC_READ_STROBE_TO_DATA_DELAY_NS 20
`define NDC_SYNC_STAGES 2
`define NDC_RD_WAIT_CYC \
  (((`NDC_READ_STROBE_TO_DATA_DELAY_NS + `NDC_LINK_PERIOD_NS - 1) / `NDC_LINK_PERIOD_NS) \
  + `NDC_SYNC_STAGES)
`define NDC_RD_TIMEOUT_CYC 15

// Reset values of pin outputs
`define NDC_CE_N_RST 8'hff
`define NDC_WP_N_RST 2'h0

`endif

/* core/ndc_pkg.sv */
package ndc_pkg;

  typedef enum logic [2:0]
  {
    NDC_OP_CMD = 3'h0,
    NDC_OP_ADDR = 3'h1,
    NDC_OP_WRITE = 3'h2,
    NDC_OP_READ = 3'h3,
    NDC_OP_WAIT = 3'h4
  } ndc_op_e;

  typedef struct packed
  {
    ndc_op_e op;
    logic [2:0] chip;
    logic [15:0] data;
  } ndc_req_s;

  typedef struct packed
  {
    logic err;
    logic [15:0] data;
  } ndc_rsp_s;

  typedef struct packed
  {
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic [7:0] io_out;
    logic io_oe_n;
    logic dqs_out;
    logic dqs_oe_n;
  } ndc_pin_s;

  typedef enum logic [2:0]
  {
    NDC_S_IDLE = 3'b001,
    NDC_S_LINK = 3'b010,
    NDC_S_WAIT = 3'b100
  } ndc_sys_state_e;

  typedef enum logic [8:0]
  {
    NDC_L_IDLE = 9'b000000001,
    NDC_L_CA_SET = 9'b000000010,
    NDC_L_CA_LATCH = 9'b000000100,
    NDC_L_W0 = 9'b000001000,
    NDC_L_W1 = 9'b000010000,
    NDC_L_W2 = 9'b000100000,
    NDC_L_W3 = 9'b001000000,
    NDC_L_R_LO = 9'b010000000,
    NDC_L_R_HI = 9'b100000000
  } ndc_link_state_e;

  localparam ndc_pin_s NDC_PIN_IDLE = '{cle: 1'b0, ale: 1'b0, we_n: 1'b1,
    read_strobe_n: 1'b1, io_out: 8'h00, io_oe_n: 1'b1, dqs_out: 1'b0, dqs_oe_n: 1'b1};

endpackage

/* core/ndc_pulse_cross.sv */
`timescale 1ns/1ps
module ndc_pulse_cross
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic toggle_in,
  output logic pulse
);
  logic synced;
  logic last;

  ndc_sync #(.W(1)) u_sync
  (
    .clk(clk),
    .arst_n(arst_n),
    .din(toggle_in),
    .dout(synced)
  );

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      last <= 1'b0;
    else
      last <= synced;
  end

  assign pulse = synced ^ last;
endmodule

/* core/ndc_sync.sv */
`timescale 1ns/1ps
module ndc_sync #(parameter int W = 1)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= '0;
      dout <= '0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

/* verification/ndc_flash_model.sv */
`timescale 1ns/1ps
module ndc_flash_model
(
  input wire ndc_pkg::ndc_pin_s pin,
  input wire logic [3:0] ce_n,
  input wire logic wp_n,
  output logic [7:0] io,
  output logic dqs,
  output wire [1:0] rb_n,
  output logic [7:0] cmd,
  output logic [7:0] col,
  output logic [15:0] wd
);
  logic [1:0] busy = 2'h0;
  logic sel;
  int na = 0;

  assign sel = ~&ce_n;
  assign rb_n[0] = busy[0] ? 1'b0 : 1'bz;
  assign rb_n[1] = busy[1] ? 1'b0 : 1'bz;
  initial {io, dqs, cmd, col, wd} = '0;
  // Released bus shows the inverse, never a stale byte
  always @(posedge &ce_n) {io, dqs} = ~{io, dqs};
  // Busy runs out regardless of chip enable
  always @(posedge busy[0]) #800 busy[0] = 1'b0;
  always @(posedge busy[1]) #800 busy[1] = 1'b0;

  always @(posedge pin.we_n)
    if (sel && pin.cle)
    begin
      cmd = pin.io_out;
      na = 0;
      if (cmd == 8'h10 && wp_n)
        busy[~&ce_n[3:2]] = 1'b1;
    end
    else if (sel && pin.ale)
    begin
      if (na == 0)
        col = pin.io_out;
      na++;
    end

  always @(pin.read_strobe_n)
    if (sel)
    begin
      #20;
      io = col;
      dqs = ~pin.read_strobe_n;
      col = col + 8'h01;
    end

  always @(pin.dqs_out)
    if (sel && !pin.dqs_oe_n)
      wd = {pin.io_out, wd[15:8]};
endmodule

/* verification/ndc_host_sva.sv */
`timescale 1ns/1ps
module ndc_host_sva
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_link,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire ndc_pkg::ndc_rsp_s rsp,
  input wire logic protect,
  input wire logic [7:0] chip_ready,
  input wire ndc_pkg::ndc_pin_s [1:0] pins,
  input wire logic [7:0] ce_n,
  input wire logic [1:0] wp_n,
  input wire logic [3:0] rb_n
);
  a_latch_excl: assert property (@(posedge clk_link) disable iff (!arst_n)
    !(pins[0].cle && pins[0].ale) && !(pins[1].cle && pins[1].ale))
    else $error("cle with ale");
  a_strobe_qual: assert property (@(posedge clk_link) disable iff (!arst_n)
    !pins[0].we_n |-> !pins[0].io_oe_n && (pins[0].cle || pins[0].ale))
    else $error("bare write strobe");
  a_latch_stable: assert property (@(posedge clk_link) disable iff (!arst_n)
    $rose(pins[1].we_n) |-> $stable({pins[1].cle, pins[1].ale, pins[1].io_out}))
    else $error("byte moved at latch");
  a_read_hiz: assert property (@(posedge clk_link) disable iff (!arst_n)
    !pins[1].read_strobe_n |-> pins[1].io_oe_n)
    else $error("io driven in read");
  a_dqs_centre: assert property (@(posedge clk_link) disable iff (!arst_n)
    !pins[0].dqs_oe_n && $changed(pins[0].dqs_out) |-> $stable(pins[0].io_out))
    else $error("data moved at strobe");
  a_one_chip: assert property (@(posedge clk_link) disable iff (!arst_n)
    $onehot0(~ce_n))
    else $error("two chips enabled");
  a_wp_follow: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $past(arst_n) |-> wp_n == {2{!$past(protect)}})
    else $error("wp_n off protect");
  a_ready_sync: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $past(arst_n, 2) |-> chip_ready[1:0] == {2{$past(rb_n[0], 2)}}
      && chip_ready[7] == $past(rb_n[3], 2))
    else $error("chip_ready off rb_n");
  a_rsp_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rsp_valid |=> !rsp_valid)
    else $error("long rsp_valid");
  a_req_answer: assert property (@(posedge clk_sys) disable iff (!arst_n)
    req_valid && req_ready |-> ##[1:900] rsp_valid)
    else $error("no answer");
  c_err: cover property (@(posedge clk_sys) rsp_valid && rsp.err);
  c_write: cover property (@(posedge clk_link) $rose(pins[0].dqs_out) && !pins[0].dqs_oe_n);
  c_read: cover property (@(posedge clk_link) $fell(pins[1].read_strobe_n));
endmodule

bind ndc_host ndc_host_sva chk (.clk_sys, .arst_n, .clk_link, .req_valid, .req_ready,
  .rsp_valid, .rsp, .protect, .chip_ready, .pins, .ce_n, .wp_n, .rb_n);

/* verification/ndc_host_tb.sv */
`timescale 1ns/1ps
module ndc_host_tb;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  ndc_pkg::ndc_req_s req = '0;
  logic protect = 1'b0;
  logic req_ready;
  logic rsp_valid;
  ndc_pkg::ndc_rsp_s rsp;
  ndc_pkg::ndc_rsp_s r;
  logic [7:0] chip_ready;
  ndc_pkg::ndc_pin_s [1:0] pins;
  logic [7:0] ce_n;
  logic [1:0] wp_n;
  wire [1:0][7:0] io_in;
  wire [1:0] dqs_in;
  wire [3:0] rb_n;
  wire [1:0][7:0] mcmd;
  wire [1:0][7:0] mcol;
  wire [1:0][15:0] mwd;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;

  pullup pu[3:0] (rb_n);
  always #20 clk_sys = ~clk_sys;
  always #16 clk_link = ~clk_link;

  ndc_host uut (.clk_sys, .arst_n, .clk_link, .req_valid, .req_ready, .req, .rsp_valid,
    .rsp, .protect, .chip_ready, .pins, .ce_n, .wp_n, .io_in, .dqs_in, .rb_n);

  for (genvar k = 0; k < 2; k++)
  begin : g_dev
    ndc_flash_model dev (.pin(pins[k]), .ce_n(ce_n[4*k+:4]), .wp_n(wp_n[k]),
      .io(io_in[k]), .dqs(dqs_in[k]), .rb_n(rb_n[2*k+:2]), .cmd(mcmd[k]),
      .col(mcol[k]), .wd(mwd[k]));
  end

  task automatic wrap_up;
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic xfer(input logic [2:0] op, input logic [2:0] c, input logic [15:0] d);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{op: ndc_pkg::ndc_op_e'(op), chip: c, data: d};
    @(posedge clk_sys);
    while (req_ready !== 1'b1)
      @(posedge clk_sys);
    req_valid <= 1'b0;
    #1;
    while (rsp_valid !== 1'b1)
    begin
      @(posedge clk_sys);
      #1;
    end
    r = rsp;
  endtask

  task automatic t_rw(input logic [2:0] c);
    int k;
    k = c[2];
    xfer(ndc_pkg::NDC_OP_CMD, c, 16'h0005);
    chk("cmd", mcmd[k], 8'h05);
    chk("ce_n", ce_n, {~(8'h01 << c)});
    xfer(ndc_pkg::NDC_OP_ADDR, c, {8'h00, 8'h3c + c});
    xfer(ndc_pkg::NDC_OP_ADDR, c, 16'h0077);
    chk("col", mcol[k], 8'h3c + c);
    xfer(ndc_pkg::NDC_OP_WRITE, c, 16'ha55a);
    chk("wdata", mwd[k], 16'ha55a);
    xfer(ndc_pkg::NDC_OP_READ, c, 16'h0000);
    chk("rdata", r, {1'b0, 8'h3d + c, 8'h3c + c});
  endtask

  task automatic t_busy(input logic p);
    @(posedge clk_sys);
    protect <= p;
    xfer(ndc_pkg::NDC_OP_CMD, 3'h6, 16'h0010);
    chk("wp_n", wp_n, {2{~p}});
    repeat (3) @(posedge clk_sys);
    chk("busy", chip_ready[6], p);
    xfer(ndc_pkg::NDC_OP_WAIT, 3'h6, 16'h0000);
    chk("ready", chip_ready[6], 1'b1);
    chk("wait_rsp", r, 17'h00000);
  endtask

  task automatic t_plane;
    logic [7:0] ok [3] = '{8'h70, 8'hf1, 8'hff};
    xfer(ndc_pkg::NDC_OP_CMD, 3'h1, 16'h0011);
    xfer(ndc_pkg::NDC_OP_CMD, 3'h1, 16'h0000);
    chk("refused", {r.err, mcmd[0]}, 9'h111);
    foreach (ok[i])
    begin
      xfer(ndc_pkg::NDC_OP_CMD, 3'h1, {8'h00, ok[i]});
      chk("allowed", {r.err, mcmd[0]}, {1'b0, ok[i]});
    end
    xfer(ndc_pkg::NDC_OP_CMD, 3'h1, 16'h0081);
    xfer(3'h7, 3'h1, 16'h0000);
    chk("bad_op", r.err, 1'b1);
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      wrap_up;
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_sys);
    chk("rst_ce", ce_n, 8'hff);
    chk("rst_pins", pins, {2{ndc_pkg::NDC_PIN_IDLE}});
    chk("rst_ready", req_ready, 1'b1);
    chk("rst_rsp", {rsp_valid, rsp}, 18'h00000);
    arst_n <= 1'b1;
    t_rw(3'h2);
    t_rw(3'h7);
    t_busy(1'b0);
    t_busy(1'b1);
    t_plane;
    wrap_up;
  end
endmodule
